// ==== core/serial_sfr_pkg.sv ====
// Constants, types and register map for the serial channel enable/flag registers.
// Assumes an AXI4-Lite master on the processor side and two serial channels that
// report buffer events as one-cycle pulses synchronous to aclk.
//
// Function
// - first module enable bit 7 turns channel 0 transmitter on; resets 0.
// - first module enable bit 6 turns channel 0 receiver on; resets 0.
// - second module enable bit 5 turns channel 1 transmitter on; resets 0.
// - second module enable bit 4 turns channel 1 receiver on; resets 0.
// - first interrupt enable bit 7 gates channel 0 transmit flag; resets 0.
// - first interrupt enable bit 6 gates channel 0 receive flag; resets 0.
// - second interrupt enable bit 5 gates channel 1 transmit flag; resets 0.
// - second interrupt enable bit 4 gates channel 1 receive flag; resets 0.
// - transmit flag sets when transmit buffer empties; bit 7 or 5; resets 1.
// - receive flag sets on complete character; bit 6 or 4; resets 0.
// - bits not owned by the serial channels are neither stored nor driven here.
// - reading a receive buffer clears that channel's receive flag.
// - writing a transmit buffer clears that channel's transmit flag.
// - soft reset clears interrupt enables and receive flag, sets transmit flag.
package serial_sfr_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_ME_FIRST = 8'h00;
  localparam logic [7:0] OFF_ME_SECOND = 8'h04;
  localparam logic [7:0] OFF_IE_FIRST = 8'h08;
  localparam logic [7:0] OFF_IE_SECOND = 8'h0c;
  localparam logic [7:0] OFF_IFG_FIRST = 8'h10;
  localparam logic [7:0] OFF_IFG_SECOND = 8'h14;
  localparam logic [7:0] OFF_EVT_STATUS = 8'h18;
  localparam logic [7:0] OFF_EVT_MASK = 8'h1c;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned TX_POS_CH0 = 7;
  localparam int unsigned RX_POS_CH0 = 6;
  localparam int unsigned TX_POS_CH1 = 5;
  localparam int unsigned RX_POS_CH1 = 4;
  localparam int unsigned NUM_CH = 2;
  localparam logic ENABLE_RST = 1'b0;
  localparam logic TX_FLAG_RST = 1'b1;
  localparam logic RX_FLAG_RST = 1'b0;
  localparam logic [3:0] EVT_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    W_IDLE = 2'b01,
    W_RESP = 2'b10
  } wr_state_t;

  typedef struct packed {
    logic tx_empty;   // transmit buffer moved to shift register
    logic tx_load;    // software wrote the transmit buffer
    logic rx_done;    // complete character landed in receive buffer
    logic rx_read;    // software read the receive buffer
    logic soft_reset; // channel soft reset bit, level
  } ch_evt_t;

  typedef struct packed {
    logic tx_on;
    logic rx_on;
    logic tx_ie;
    logic rx_ie;
    logic tx_flag;
    logic rx_flag;
  } ch_regs_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axi_rsp_t;

  typedef struct packed {
    wr_state_t wst;
    logic aw_have;
    logic w_have;
    logic [7:0] waddr;
    logic [7:0] wbyte;
    logic wen;
    ch_regs_t [1:0] ch;
    logic [3:0] evt;
    logic [3:0] mask;
    logic [1:0] tx_irq;
    logic [1:0] rx_irq;
    logic irq;
    axi_rsp_t rsp;
  } state_t;

endpackage : serial_sfr_pkg

// ==== core/serial_sfr.sv ====
// Serial channel enable, interrupt enable and flag registers behind AXI4-Lite.
// Assumes the channel logic drives ch_evt pulses and the soft reset level on aclk.
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module serial_sfr (
  input wire logic aclk,                             // 200 MHz system clock
  input wire logic aresetn,                          // synchronous reset, low
  input wire serial_sfr_pkg::axi_req_t req,          // AXI4-Lite master to slave
  output serial_sfr_pkg::axi_rsp_t rsp,              // AXI4-Lite slave to master
  input wire serial_sfr_pkg::ch_evt_t [1:0] ch_evt,  // per channel events
  output logic [1:0] ch_tx_on,                       // transmitter enables
  output logic [1:0] ch_rx_on,                       // receiver enables
  output logic [1:0] ch_tx_irq,                      // transmit interrupt requests
  output logic [1:0] ch_rx_irq,                      // receive interrupt requests
  output logic irq                                   // summary event interrupt
);
  import serial_sfr_pkg::*;

  state_t s;
  state_t next_s;
  logic wr_fire;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic int unsigned tx_pos(input int unsigned c);
    return (c == 0) ? TX_POS_CH0 : TX_POS_CH1;
  endfunction : tx_pos

  function automatic int unsigned rx_pos(input int unsigned c);
    return (c == 0) ? RX_POS_CH0 : RX_POS_CH1;
  endfunction : rx_pos

  function automatic logic mapped(input logic [7:0] a);
    return (a[7:2] <= OFF_EVT_MASK[7:2]);
  endfunction : mapped

  // unowned bits read zero: other modules keep their own copies
  function automatic logic [7:0] read_byte(input state_t st, input logic [7:0] a);
    logic [7:0] rb;
    rb = 8'h00;
    for (int unsigned c = 0; c < NUM_CH; c++) begin
      if (a[7:2] == (c == 0 ? OFF_ME_FIRST[7:2] : OFF_ME_SECOND[7:2])) begin
        rb[tx_pos(c)] = st.ch[c].tx_on;
        rb[rx_pos(c)] = st.ch[c].rx_on;
      end
      if (a[7:2] == (c == 0 ? OFF_IE_FIRST[7:2] : OFF_IE_SECOND[7:2])) begin
        rb[tx_pos(c)] = st.ch[c].tx_ie;
        rb[rx_pos(c)] = st.ch[c].rx_ie;
      end
      if (a[7:2] == (c == 0 ? OFF_IFG_FIRST[7:2] : OFF_IFG_SECOND[7:2])) begin
        rb[tx_pos(c)] = st.ch[c].tx_flag;
        rb[rx_pos(c)] = st.ch[c].rx_flag;
      end
    end
    if (a[7:2] == OFF_EVT_STATUS[7:2]) begin
      rb[3:0] = st.evt;
    end
    if (a[7:2] == OFF_EVT_MASK[7:2]) begin
      rb[3:0] = st.mask;
    end
    return rb;
  endfunction : read_byte

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    wr_fire = 1'b0;
    // write channel: address and data taken in either order
    unique case (s.wst)
      W_IDLE: begin
        if (req.awvalid && s.rsp.awready) begin
          next_s.aw_have = 1'b1;
          next_s.waddr = req.awaddr;
          next_s.rsp.awready = 1'b0;
        end
        if (req.wvalid && s.rsp.wready) begin
          next_s.w_have = 1'b1;
          next_s.wbyte = req.wdata[7:0];
          next_s.wen = req.wstrb[0];
          next_s.rsp.wready = 1'b0;
        end
        if (s.aw_have && s.w_have) begin
          wr_fire = 1'b1;
          next_s.aw_have = 1'b0;
          next_s.w_have = 1'b0;
          next_s.rsp.bvalid = 1'b1;
          next_s.rsp.bresp = mapped(s.waddr) ? RESP_OKAY : RESP_SLVERR;
          next_s.wst = W_RESP;
        end
      end
      W_RESP: begin
        if (req.bready) begin
          next_s.rsp.bvalid = 1'b0;
          next_s.rsp.awready = 1'b1;
          next_s.rsp.wready = 1'b1;
          next_s.wst = W_IDLE;
        end
      end
    endcase
    // read channel
    if (s.rsp.rvalid) begin
      if (req.rready) begin
        next_s.rsp.rvalid = 1'b0;
        next_s.rsp.arready = 1'b1;
      end
    end else if (req.arvalid && s.rsp.arready) begin
      next_s.rsp.arready = 1'b0;
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rdata = {24'h000000, read_byte(s, req.araddr)};
      next_s.rsp.rresp = mapped(req.araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    // event status is write-one-to-clear; new events below win
    if (wr_fire && s.wen && s.waddr[7:2] == OFF_EVT_STATUS[7:2]) begin
      next_s.evt = s.evt & ~s.wbyte[3:0];
    end
    if (wr_fire && s.wen && s.waddr[7:2] == OFF_EVT_MASK[7:2]) begin
      next_s.mask = s.wbyte[3:0];
    end
    for (int unsigned c = 0; c < NUM_CH; c++) begin
      if (wr_fire && s.wen
          && s.waddr[7:2] == (c == 0 ? OFF_ME_FIRST[7:2] : OFF_ME_SECOND[7:2])) begin
        next_s.ch[c].tx_on = s.wbyte[tx_pos(c)];
        next_s.ch[c].rx_on = s.wbyte[rx_pos(c)];
      end
      if (wr_fire && s.wen
          && s.waddr[7:2] == (c == 0 ? OFF_IE_FIRST[7:2] : OFF_IE_SECOND[7:2])) begin
        next_s.ch[c].tx_ie = s.wbyte[tx_pos(c)];
        next_s.ch[c].rx_ie = s.wbyte[rx_pos(c)];
      end
      if (wr_fire && s.wen
          && s.waddr[7:2] == (c == 0 ? OFF_IFG_FIRST[7:2] : OFF_IFG_SECOND[7:2])) begin
        next_s.ch[c].tx_flag = s.wbyte[tx_pos(c)];
        next_s.ch[c].rx_flag = s.wbyte[rx_pos(c)];
      end
      if (ch_evt[c].tx_load) begin
        next_s.ch[c].tx_flag = 1'b0;
      end
      if (ch_evt[c].rx_read) begin
        next_s.ch[c].rx_flag = 1'b0;
      end
      // hardware set beats load, read and register-write clears in the same cycle; soft reset below still wins
      if (ch_evt[c].tx_empty) begin
        next_s.ch[c].tx_flag = 1'b1;
      end
      if (ch_evt[c].rx_done) begin
        next_s.ch[c].rx_flag = 1'b1;
      end
      // soft reset holds the channel quiet; enables of the module survive
      if (ch_evt[c].soft_reset) begin
        next_s.ch[c].tx_ie = 1'b0;
        next_s.ch[c].rx_ie = 1'b0;
        next_s.ch[c].rx_flag = 1'b0;
        next_s.ch[c].tx_flag = 1'b1;
      end
      if (next_s.ch[c].tx_flag && !s.ch[c].tx_flag) begin
        next_s.evt[2 * c] = 1'b1;
      end
      if (next_s.ch[c].rx_flag && !s.ch[c].rx_flag) begin
        next_s.evt[2 * c + 1] = 1'b1;
      end
      next_s.tx_irq[c] = next_s.ch[c].tx_flag & next_s.ch[c].tx_ie;
      next_s.rx_irq[c] = next_s.ch[c].rx_flag & next_s.ch[c].rx_ie;
    end
    next_s.irq = |(next_s.evt & next_s.mask);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.wst <= W_IDLE;
      s.rsp.awready <= 1'b1;
      s.rsp.wready <= 1'b1;
      s.rsp.arready <= 1'b1;
      s.evt <= EVT_RST;
      s.mask <= MASK_RST;
      for (int unsigned c = 0; c < NUM_CH; c++) begin
        s.ch[c].tx_on <= ENABLE_RST;
        s.ch[c].rx_on <= ENABLE_RST;
        s.ch[c].tx_ie <= ENABLE_RST;
        s.ch[c].rx_ie <= ENABLE_RST;
        s.ch[c].tx_flag <= TX_FLAG_RST;
        s.ch[c].rx_flag <= RX_FLAG_RST;
      end
    end else begin
      s <= next_s;
    end
  end

  assign rsp = s.rsp;
  assign ch_tx_irq = s.tx_irq;
  assign ch_rx_irq = s.rx_irq;
  assign irq = s.irq;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    assign ch_tx_on[g] = s.ch[g].tx_on;
    assign ch_rx_on[g] = s.ch[g].rx_on;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_ch0_tx_enable: assert property (wr_fire && s.wen && s.waddr == OFF_ME_FIRST |=>
    ch_tx_on[0] == $past(s.wbyte[7])) else $error("ch0 transmit enable not written");
  a_ch0_rx_enable: assert property (wr_fire && s.wen && s.waddr == OFF_ME_FIRST |=>
    ch_rx_on[0] == $past(s.wbyte[6])) else $error("ch0 receive enable not written");
  a_ch1_tx_enable: assert property (wr_fire && s.wen && s.waddr == OFF_ME_SECOND |=>
    ch_tx_on[1] == $past(s.wbyte[5])) else $error("ch1 transmit enable not written");
  a_ch1_rx_enable: assert property (wr_fire && s.wen && s.waddr == OFF_ME_SECOND |=>
    ch_rx_on[1] == $past(s.wbyte[4])) else $error("ch1 receive enable not written");
  a_ch0_ie_write: assert property (wr_fire && s.wen && s.waddr == OFF_IE_FIRST
    && !ch_evt[0].soft_reset |=> s.ch[0].tx_ie == $past(s.wbyte[7])
    && s.ch[0].rx_ie == $past(s.wbyte[6])) else $error("ch0 interrupt enables wrong");
  a_ch1_ie_write: assert property (wr_fire && s.wen && s.waddr == OFF_IE_SECOND
    && !ch_evt[1].soft_reset |=> s.ch[1].tx_ie == $past(s.wbyte[5])
    && s.ch[1].rx_ie == $past(s.wbyte[4])) else $error("ch1 interrupt enables wrong");
  a_tx_flag_set: assert property (ch_evt[0].tx_empty |=> s.ch[0].tx_flag)
    else $error("transmit flag not set on empty buffer");
  a_rx_flag_set: assert property (ch_evt[1].rx_done && !ch_evt[1].soft_reset |=>
    s.ch[1].rx_flag) else $error("receive flag not set on character");
  a_unowned_zero: assert property (s.rsp.rvalid |-> s.rsp.rdata[31:8] == 24'h000000)
    else $error("unowned bits read nonzero");
  a_rx_read_clear: assert property (ch_evt[0].rx_read && !ch_evt[0].rx_done |=>
    !s.ch[0].rx_flag) else $error("receive flag survived buffer read");
  a_tx_load_clear: assert property (ch_evt[1].tx_load && !ch_evt[1].tx_empty
    && !ch_evt[1].soft_reset |=> !s.ch[1].tx_flag) else $error("transmit flag survived load");
  a_soft_reset: assert property (ch_evt[0].soft_reset
    && !(wr_fire && s.waddr[7:2] == OFF_ME_FIRST[7:2]) |=> s.ch[0].tx_flag
    && !s.ch[0].rx_flag && !s.ch[0].tx_ie && !s.ch[0].rx_ie
    && $stable(ch_tx_on[0]) && $stable(ch_rx_on[0])) else $error("soft reset did not quiet channel");
  a_irq_and: assert property (ch_tx_irq[1] == (s.ch[1].tx_flag && s.ch[1].tx_ie)
    && ch_rx_irq[0] == (s.ch[0].rx_flag && s.ch[0].rx_ie))
    else $error("request not flag and enable");
  a_tx1_flag_set: assert property (ch_evt[1].tx_empty |=> s.ch[1].tx_flag)
    else $error("channel 1 transmit flag not set on empty buffer");
  a_rx0_flag_set: assert property (ch_evt[0].rx_done && !ch_evt[0].soft_reset |=>
    s.ch[0].rx_flag) else $error("channel 0 receive flag not set on character");
  a_rx1_read_clear: assert property (ch_evt[1].rx_read && !ch_evt[1].rx_done |=>
    !s.ch[1].rx_flag) else $error("channel 1 receive flag survived buffer read");
  a_tx0_load_clear: assert property (ch_evt[0].tx_load && !ch_evt[0].tx_empty
    && !ch_evt[0].soft_reset |=> !s.ch[0].tx_flag)
    else $error("channel 0 transmit flag survived load");
  a_ch1_soft_reset: assert property (ch_evt[1].soft_reset
    && !(wr_fire && s.waddr[7:2] == OFF_ME_SECOND[7:2]) |=> s.ch[1].tx_flag
    && !s.ch[1].rx_flag && !s.ch[1].tx_ie && !s.ch[1].rx_ie
    && $stable(ch_tx_on[1]) && $stable(ch_rx_on[1]))
    else $error("soft reset did not quiet channel 1");
  a_irq_and_cross: assert property (ch_tx_irq[0] == (s.ch[0].tx_flag && s.ch[0].tx_ie)
    && ch_rx_irq[1] == (s.ch[1].rx_flag && s.ch[1].rx_ie))
    else $error("channel request not flag and enable");
  a_me_first_hold: assert property (!(wr_fire && s.waddr[7:2] == OFF_ME_FIRST[7:2]) |=>
    $stable(ch_tx_on[0]) && $stable(ch_rx_on[0]))
    else $error("channel 0 enables moved unwritten");
  a_me_second_hold: assert property (!(wr_fire && s.waddr[7:2] == OFF_ME_SECOND[7:2]) |=>
    $stable(ch_tx_on[1]) && $stable(ch_rx_on[1]))
    else $error("channel 1 enables moved unwritten");
  a_flag0_write: assert property (wr_fire && s.wen && s.waddr[7:2] == OFF_IFG_FIRST[7:2]
    && ch_evt[0] == '0 |=> s.ch[0].tx_flag == $past(s.wbyte[7])
    && s.ch[0].rx_flag == $past(s.wbyte[6])) else $error("channel 0 flags not written");
  a_flag1_write: assert property (wr_fire && s.wen && s.waddr[7:2] == OFF_IFG_SECOND[7:2]
    && ch_evt[1] == '0 |=> s.ch[1].tx_flag == $past(s.wbyte[5])
    && s.ch[1].rx_flag == $past(s.wbyte[4])) else $error("channel 1 flags not written");
  a_evt_on_rise: assert property ($rose(s.ch[0].tx_flag) |-> s.evt[0])
    else $error("channel 0 transmit event not recorded");
  a_evt_rx1_rise: assert property ($rose(s.ch[1].rx_flag) |-> s.evt[3])
    else $error("channel 1 receive event not recorded");
  a_evt_sticky: assert property (s.evt[1] && !(wr_fire && s.waddr[7:2] == OFF_EVT_STATUS[7:2])
    |=> s.evt[1]) else $error("event status bit lost without a clear");
  a_evt_clear: assert property (wr_fire && s.wen && s.waddr[7:2] == OFF_EVT_STATUS[7:2]
    && s.wbyte[0] |=> !s.evt[0] || $rose(s.ch[0].tx_flag))
    else $error("event status bit not cleared by write of one");
  a_mask_write: assert property (wr_fire && s.wen && s.waddr[7:2] == OFF_EVT_MASK[7:2]
    |=> s.mask == $past(s.wbyte[3:0])) else $error("event mask not written");

  // ----------------------------------------------------------------
  // assertions: register bus
  // ----------------------------------------------------------------
  a_bvalid_hold: assert property (s.rsp.bvalid && !req.bready |=> s.rsp.bvalid)
    else $error("write response dropped early");
  a_wst_onehot: assert property ($onehot(s.wst)) else $error("write state not one-hot");
  a_write_answer: assert property (s.aw_have && s.w_have |=> s.rsp.bvalid)
    else $error("write response not raised after commit");
  a_read_answer: assert property (req.arvalid && s.rsp.arready && !s.rsp.rvalid
    |=> s.rsp.rvalid) else $error("read data not raised after address");
  a_rvalid_hold: assert property (s.rsp.rvalid && !req.rready |=> s.rsp.rvalid
    && $stable(s.rsp.rdata)) else $error("read data dropped early");
  a_ready_low: assert property (s.rsp.bvalid |-> !s.rsp.awready && !s.rsp.wready)
    else $error("write channel ready during response");
  a_bad_write: assert property (wr_fire && !mapped(s.waddr) |=> s.rsp.bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  a_bad_read: assert property (req.arvalid && s.rsp.arready && !s.rsp.rvalid
    && !mapped(req.araddr) |=> s.rsp.rdata == 32'h00000000 && s.rsp.rresp == RESP_SLVERR)
    else $error("unmapped read not refused");

endmodule : serial_sfr

// ==== sim/testbench.sv ====
// Self-checking bench for the serial channel enable, interrupt enable and flag registers.
// Assumes the block answers AXI4-Lite on aclk and takes channel events as one-cycle pulses.
`timescale 1ns/1ps
module testbench;
  import serial_sfr_pkg::*;
  // ----------------------------------------------------------------
  // hookup
  // ----------------------------------------------------------------
  localparam logic [4:0] TXE = 5'h10;
  localparam logic [4:0] TXL = 5'h08;
  localparam logic [4:0] RXD = 5'h04;
  localparam logic [4:0] RXR = 5'h02;
  logic aclk;
  logic aresetn;
  axi_req_t req;
  axi_rsp_t rsp;
  ch_evt_t [1:0] ev;
  logic [1:0] tx_on, rx_on, tx_irq, rx_irq;
  logic irq;
  int n_errors;
  int n_tests;
  serial_sfr dut (.aclk(aclk), .aresetn(aresetn), .req(req), .rsp(rsp), .ch_evt(ev),
    .ch_tx_on(tx_on), .ch_rx_on(rx_on), .ch_tx_irq(tx_irq), .ch_rx_irq(rx_irq), .irq(irq));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic hang(input string what);
    n_errors++;
    $display("CHECK FAILED %s expected handshake seen timeout", what);
    complete_run();
  endtask : hang
  // ----------------------------------------------------------------
  // bus cycles: ready/valid sampled in the settled half before each edge
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_left;
    logic w_left;
    logic aw_go;
    logic w_go;
    int i;
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.wvalid <= 1'b1;
    aw_left = 1'b1;
    w_left = 1'b1;
    for (i = 0; i < 64 && (aw_left || w_left); i++) begin
      @(negedge aclk);
      aw_go = aw_left && rsp.awready === 1'b1;
      w_go = w_left && rsp.wready === 1'b1;
      @(posedge aclk);
      if (aw_go) req.awvalid <= 1'b0;
      if (aw_go) aw_left = 1'b0;
      if (w_go) req.wvalid <= 1'b0;
      if (w_go) w_left = 1'b0;
    end
    if (aw_left || w_left) hang("write address and data");
    for (i = 0; i < 64; i++) begin
      @(negedge aclk);
      if (rsp.bvalid === 1'b1) break;
    end
    if (i == 64) hang("write response");
    r = rsp.bresp;
    @(posedge aclk);
  endtask : wr
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic go;
    int i;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    go = 1'b0;
    for (i = 0; i < 64 && !go; i++) begin
      @(negedge aclk);
      go = rsp.arready === 1'b1;
      @(posedge aclk);
    end
    if (!go) hang("read address");
    req.arvalid <= 1'b0;
    for (i = 0; i < 64; i++) begin
      @(negedge aclk);
      if (rsp.rvalid === 1'b1) break;
    end
    if (i == 64) hang("read data");
    d = rsp.rdata;
    r = rsp.rresp;
    @(posedge aclk);
  endtask : rd_reg
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check("write response", r, RESP_OKAY);
  endtask : put
  task automatic get_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd_reg(a, d, r);
    check(what, d, exp);
  endtask : get_chk
  // irq, tx_on, rx_on, tx_irq, rx_irq of one channel, looked at between edges
  task automatic look(input int c, input logic [4:0] exp);
    @(negedge aclk);
    check("irq enables requests", {irq, tx_on[c], rx_on[c], tx_irq[c], rx_irq[c]}, exp);
    @(posedge aclk);
  endtask : look
  task automatic pulse(input int c, input logic [4:0] m);
    ev[c] <= ch_evt_t'(ev[c] | m);
    @(posedge aclk);
    ev[c] <= ch_evt_t'(ev[c] & ~m);
    @(posedge aclk);
  endtask : pulse
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    int c;
    logic [31:0] tx;
    logic [31:0] both;
    logic [7:0] me;
    logic [7:0] ie;
    logic [7:0] fl;
    logic [31:0] d;
    logic [1:0] r;
    aresetn = 1'b0;
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    ev = '0;
    n_errors = 0;
    n_tests = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    get_chk("module enable first", OFF_ME_FIRST, 32'h0);
    get_chk("module enable second", OFF_ME_SECOND, 32'h0);
    get_chk("irq enable first", OFF_IE_FIRST, 32'h0);
    get_chk("irq enable second", OFF_IE_SECOND, 32'h0);
    get_chk("flags first", OFF_IFG_FIRST, 32'h80);
    get_chk("flags second", OFF_IFG_SECOND, 32'h20);
    $display("test reset values done");
    for (c = 0; c < 2; c++) begin
      tx = 32'h1 << (c ? TX_POS_CH1 : TX_POS_CH0);
      both = tx | (32'h1 << (c ? RX_POS_CH1 : RX_POS_CH0));
      me = c ? OFF_ME_SECOND : OFF_ME_FIRST;
      ie = c ? OFF_IE_SECOND : OFF_IE_FIRST;
      fl = c ? OFF_IFG_SECOND : OFF_IFG_FIRST;
      look(c, 5'b00000);
      put(me, 32'hff);
      get_chk("module enable", me, both);
      look(c, 5'b01100);
      put(me, tx);
      look(c, 5'b01000);
      put(ie, 32'hff);
      get_chk("irq enable", ie, both);
      look(c, 5'b01010);
      pulse(c, TXL);
      get_chk("flags", fl, 32'h0);
      look(c, 5'b01000);
      pulse(c, TXE);
      pulse(c, RXD);
      get_chk("flags", fl, both);
      look(c, 5'b01011);
      put(ie, tx);
      look(c, 5'b01010);
      pulse(c, RXR);
      get_chk("flags", fl, tx);
      pulse(c, TXL | RXD);
      put(ie, 32'hff);
      ev[c].soft_reset <= 1'b1;
      repeat (2) @(posedge aclk);
      get_chk("irq enable", ie, 32'h0);
      get_chk("flags", fl, tx);
      get_chk("module enable", me, tx);
      look(c, 5'b01000);
      ev[c].soft_reset <= 1'b0;
      @(posedge aclk);
      $display("test channel %0d done", c);
    end
    // summary interrupt: sticky status, one-to-clear, mask
    put(OFF_EVT_MASK, 32'hf);
    put(OFF_EVT_STATUS, 32'hf);
    get_chk("event status", OFF_EVT_STATUS, 32'h0);
    look(0, 5'b01000);
    pulse(0, RXD);
    get_chk("event status", OFF_EVT_STATUS, 32'h2);
    look(0, 5'b11000);
    put(OFF_EVT_MASK, 32'hd);
    look(0, 5'b01000);
    put(OFF_EVT_MASK, 32'hf);
    look(0, 5'b11000);
    put(OFF_EVT_STATUS, 32'h2);
    look(0, 5'b01000);
    get_chk("event status", OFF_EVT_STATUS, 32'h0);
    $display("test summary interrupt done");
    // set beats clear in one cycle; flags are writable
    pulse(1, TXL | RXR);
    pulse(1, TXE | TXL | RXD | RXR);
    get_chk("set beats clear", OFF_IFG_SECOND, 32'h30);
    put(OFF_IFG_SECOND, 32'h0);
    get_chk("flags written", OFF_IFG_SECOND, 32'h0);
    $display("test flag priority done");
    // a place outside the map is refused both ways
    wr(8'h20, 32'hff, r);
    check("unmapped write response", r, RESP_SLVERR);
    rd_reg(8'h20, d, r);
    check("unmapped read data", d, 32'h0);
    check("unmapped read response", r, RESP_SLVERR);
    $display("test unmapped access done");
    complete_run();
  end
endmodule : testbench
